// file: rtl/mcit_core_seq.v
// instruction fetch sequencer, extended RAM and port read-modify-write path
//
// Summary of operation
// - rotates on accumulator are one byte, one cycle
// - register moves one cycle, indirect moves two
// - two-byte transfers finish in two cycles
// - three-byte moves and pointer load take three
// - code_byte_move is one byte, four cycles
// - ext_ram_move is one byte, four cycles
// - ext_ram_move reaches only internal 256-byte RAM
// - push and pop take two bytes, two cycles
// - register exchange one cycle, others two cycles
// - addressed bit operations two cycles, carry-only one
// - bit to carry and back take two
// - indirect accumulator jump takes three cycles
// - two-byte branches take three cycles
// - three-byte branches take four cycles
// - plain port bit input samples the pin
// - read-modify-write on a port reads latch
// - fixed instruction set performs latch reads
// - bit writes merge into whole latch byte
// - jump_set_and_clear branches and clears set bit
`timescale 1ns/1ps
`include "mcit_regs.vh"

module mcit_core_seq (
  input wire CLOCK,
  input wire ARST_N,
  output reg [15:0] CODE_ADDR,
  input wire [7:0] CODE_DATA,
  input wire [7:0] ACC_IN,
  input wire CARRY_IN,
  input wire [15:0] DATA_POINTER_IN,
  input wire [7:0] REG_IND_IN,
  input wire COND_IN,
  input wire [15:0] RET_ADDR_IN,
  input wire [31:0] PORT_PIN_IN,
  input wire PORT_WR_EN,
  input wire [1:0] PORT_WR_SEL,
  input wire [7:0] PORT_WR_DATA,
  output wire [31:0] PORT_LATCH_OUT,
  output reg INSTR_START,
  output reg EXEC_DONE,
  output reg [7:0] EXEC_OPCODE,
  output reg [7:0] EXEC_OPERAND1,
  output reg [7:0] EXEC_OPERAND2,
  output reg BRANCH_TAKEN,
  output reg [7:0] PORT_RDATA,
  output reg ACC_LOAD,
  output reg [7:0] ACC_VALUE,
  output reg CARRY_LOAD,
  output reg CARRY_VALUE
);

  localparam NUM_PORTS = 4;

  // ********************************************************
  // sequencing state
  // ********************************************************
  reg [3:0] cnt;
  reg [7:0] op_reg;
  reg [7:0] arg1;
  reg [7:0] arg2;
  reg [15:0] ins_addr;
  reg [7:0] xram [0:(1 << `MCIT_XRAM_AW) - 1];

  wire [1:0] length;
  wire [3:0] cycles;
  wire is_branch;
  wire always_taken;

  // bytes still arriving are taken straight off the code bus
  wire [7:0] cur_op = (cnt == 4'd0) ? CODE_DATA : op_reg;
  wire [7:0] cur_arg1 = (cnt == 4'd1) ? CODE_DATA : arg1;
  wire [7:0] cur_arg2 = (cnt == 4'd2) ? CODE_DATA : arg2;
  wire [15:0] cur_ins = (cnt == 4'd0) ? CODE_ADDR : ins_addr;
  wire [15:0] pc_next = cur_ins + {14'd0, length};
  wire last = ((cnt + 4'd1) == cycles);

  mcit_decode u_decode (
    .opcode(cur_op),
    .length(length),
    .cycles(cycles),
    .is_branch(is_branch),
    .always_taken(always_taken)
  );

  // ********************************************************
  // port selection
  // ********************************************************
  wire [1:0] port_idx = cur_arg1[`MCIT_PORT_IDX_HI:`MCIT_PORT_IDX_LO];
  wire dir_port = (cur_arg1[7:6] == `MCIT_PORT_SPACE) && (cur_arg1[3:0] == `MCIT_PORT_LOW);
  wire bit_port = (cur_arg1[7:6] == `MCIT_PORT_SPACE) && !cur_arg1[`MCIT_BIT_BYTE_FLAG];
  wire [7:0] latch_byte = PORT_LATCH_OUT[{port_idx, 3'b000} +: 8];
  wire [7:0] pin_byte = PORT_PIN_IN[{port_idx, 3'b000} +: 8];
  wire latch_bit = PORT_LATCH_OUT[{port_idx, cur_arg1[2:0]}];
  wire pin_bit = PORT_PIN_IN[{port_idx, cur_arg1[2:0]}];

  // ********************************************************
  // read-modify-write on port bytes and bits
  // ********************************************************
  reg rmw_byte;
  reg [7:0] rmw_data;
  reg rmw_bit;
  reg rmw_value;

  always @* begin
    rmw_byte = 1'b1;
    rmw_data = latch_byte;
    case (cur_op)
      `MCIT_OP_ORL_DA: rmw_data = latch_byte | ACC_IN;
      `MCIT_OP_ORL_DI: rmw_data = latch_byte | cur_arg2;
      `MCIT_OP_ANL_DA: rmw_data = latch_byte & ACC_IN;
      `MCIT_OP_ANL_DI: rmw_data = latch_byte & cur_arg2;
      `MCIT_OP_XRL_DA: rmw_data = latch_byte ^ ACC_IN;
      `MCIT_OP_XRL_DI: rmw_data = latch_byte ^ cur_arg2;
      `MCIT_OP_INC_D: rmw_data = latch_byte + 8'h01;
      `MCIT_OP_DEC_D, `MCIT_OP_DEC_BNZ_D: rmw_data = latch_byte - 8'h01;
      default: rmw_byte = 1'b0;
    endcase
  end

  always @* begin
    rmw_bit = 1'b1;
    rmw_value = 1'b0;
    case (cur_op)
      `MCIT_OP_CLR_B: rmw_value = 1'b0;
      `MCIT_OP_SETB_B: rmw_value = 1'b1;
      `MCIT_OP_CPL_B: rmw_value = ~latch_bit;
      `MCIT_OP_MOV_BC: rmw_value = CARRY_IN;
      `MCIT_OP_JSET_CLR: rmw_bit = latch_bit;
      default: rmw_bit = 1'b0;
    endcase
  end

  wire do_byte = last && dir_port && rmw_byte;
  wire do_bit = last && bit_port && rmw_bit;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_port
      // the instruction's own update wins over a core write to the same port
      wire own_byte = do_byte && (port_idx == gi);
      wire own_bit = do_bit && (port_idx == gi);
      wire core_byte = PORT_WR_EN && (PORT_WR_SEL == gi) && !own_bit;
      mcit_port u_port (
        .clock(CLOCK),
        .arst_n(ARST_N),
        .byte_we(own_byte || core_byte),
        .byte_data(own_byte ? rmw_data : PORT_WR_DATA),
        .bit_we(own_bit),
        .bit_sel(cur_arg1[2:0]),
        .bit_value(rmw_value),
        .latch(PORT_LATCH_OUT[gi * 8 +: 8])
      );
    end
  endgenerate

  // ********************************************************
  // branch decision and target
  // ********************************************************
  reg taken;
  reg [15:0] target;
  wire [7:0] rel = (length == `MCIT_LEN_3) ? cur_arg2 : cur_arg1;
  wire [15:0] rel_target = pc_next + {{8{rel[7]}}, rel};

  always @* begin
    taken = COND_IN;
    case (cur_op)
      `MCIT_OP_JC: taken = CARRY_IN;
      `MCIT_OP_JNC: taken = ~CARRY_IN;
      `MCIT_OP_JZ: taken = (ACC_IN == 8'h00);
      `MCIT_OP_JNZ: taken = (ACC_IN != 8'h00);
      `MCIT_OP_JB: taken = bit_port ? pin_bit : COND_IN;
      `MCIT_OP_JNB: taken = bit_port ? ~pin_bit : COND_IN;
      `MCIT_OP_JSET_CLR: taken = bit_port ? latch_bit : COND_IN;
      `MCIT_OP_DEC_BNZ_D: taken = dir_port ? (latch_byte != 8'h01) : COND_IN;
      `MCIT_OP_CMP_BNE_AD: taken = dir_port ? (ACC_IN != pin_byte) : COND_IN;
      default: taken = COND_IN;
    endcase
    if (always_taken) begin
      taken = 1'b1;
    end
  end

  always @* begin
    target = rel_target;
    if (cur_op[3:0] == 4'h1) begin
      target = {pc_next[15:11], cur_op[7:5], cur_arg1};
    end else if (cur_op == `MCIT_OP_LONG_JUMP || cur_op == `MCIT_OP_LONG_CALL) begin
      target = {cur_arg1, cur_arg2};
    end else if (cur_op == `MCIT_OP_JMP_IND) begin
      target = DATA_POINTER_IN + {8'h00, ACC_IN};
    end else if (cur_op == `MCIT_OP_RET || cur_op == `MCIT_OP_RETI) begin
      target = RET_ADDR_IN;
    end
  end

  // ********************************************************
  // extended RAM, code table reads, carry from port bits
  // ********************************************************
  // e0/e2/e3 read, f0/f2/f3 write; e1/f1 are absolute jumps
  wire is_xmove = (cur_op[7:5] == 3'b111) && (cur_op[3:2] == 2'b00) && (cur_op[1:0] != 2'b01);
  // only the low address byte is used: no external cycle exists at all
  wire [7:0] xaddr = cur_op[1] ? REG_IND_IN : DATA_POINTER_IN[7:0];
  wire is_table = (cur_op == `MCIT_OP_TABLE_PC) || (cur_op == `MCIT_OP_TABLE_DP);
  wire [15:0] table_base = (cur_op == `MCIT_OP_TABLE_PC) ? pc_next : DATA_POINTER_IN;

  reg carry_hit;
  reg carry_bit;

  always @* begin
    carry_hit = bit_port;
    carry_bit = CARRY_IN;
    case (cur_op)
      `MCIT_OP_MOV_CB: carry_bit = pin_bit;
      `MCIT_OP_ANL_CB: carry_bit = CARRY_IN & pin_bit;
      `MCIT_OP_ANL_CNB: carry_bit = CARRY_IN & ~pin_bit;
      `MCIT_OP_ORL_CB: carry_bit = CARRY_IN | pin_bit;
      `MCIT_OP_ORL_CNB: carry_bit = CARRY_IN | ~pin_bit;
      default: carry_hit = 1'b0;
    endcase
  end

  always @(posedge CLOCK) begin
    if (last && is_xmove && cur_op[4]) begin
      xram[xaddr] <= ACC_IN;
    end
  end

  // ********************************************************
  // next fetch address and cycle count
  // ********************************************************
  reg [3:0] next_cnt;
  reg [15:0] next_code_addr;

  always @* begin
    next_cnt = cnt + 4'd1;
    next_code_addr = CODE_ADDR + 16'd1;
    if (last) begin
      // the next opcode is fetched only once all counted cycles are spent
      next_cnt = 4'd0;
      next_code_addr = (is_branch && taken) ? target : pc_next;
    end else if (is_table && cnt == `MCIT_TABLE_ADDR_CYC) begin
      next_code_addr = table_base + {8'h00, ACC_IN};
    end else if ((cnt + 4'd1) >= {2'b00, length}) begin
      next_code_addr = pc_next;
    end
  end

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt <= 4'd0;
      op_reg <= 8'h00;
      arg1 <= 8'h00;
      arg2 <= 8'h00;
      ins_addr <= `MCIT_RESET_PC;
      CODE_ADDR <= `MCIT_RESET_PC;
      INSTR_START <= 1'b1;
      EXEC_DONE <= 1'b0;
      EXEC_OPCODE <= 8'h00;
      EXEC_OPERAND1 <= 8'h00;
      EXEC_OPERAND2 <= 8'h00;
      BRANCH_TAKEN <= 1'b0;
      PORT_RDATA <= 8'h00;
      ACC_LOAD <= 1'b0;
      ACC_VALUE <= 8'h00;
      CARRY_LOAD <= 1'b0;
      CARRY_VALUE <= 1'b0;
    end else begin
      cnt <= next_cnt;
      CODE_ADDR <= next_code_addr;
      INSTR_START <= (next_cnt == 4'd0);
      if (cnt == 4'd0) begin
        op_reg <= CODE_DATA;
        ins_addr <= CODE_ADDR;
      end
      if (cnt == 4'd1) begin
        arg1 <= CODE_DATA;
      end
      // for code_byte_move this cycle returns the table byte
      if (cnt == `MCIT_TABLE_DATA_CYC) begin
        arg2 <= CODE_DATA;
      end
      EXEC_DONE <= last;
      ACC_LOAD <= last && ((is_xmove && !cur_op[4]) || is_table);
      CARRY_LOAD <= last && carry_hit;
      if (last) begin
        EXEC_OPCODE <= cur_op;
        EXEC_OPERAND1 <= cur_arg1;
        EXEC_OPERAND2 <= cur_arg2;
        BRANCH_TAKEN <= is_branch && taken;
        // modifying instructions see the latch, plain reads see the pins
        PORT_RDATA <= dir_port ? (rmw_byte ? latch_byte : pin_byte) : 8'h00;
        ACC_VALUE <= is_table ? arg2 : xram[xaddr];
        CARRY_VALUE <= carry_bit;
      end
    end
  end

endmodule

// file: common/mcit_regs.vh
// shared constants of the instruction sequencer and port read-modify-write block
`ifndef MCIT_REGS_VH
`define MCIT_REGS_VH

// instruction lengths in bytes
`define MCIT_LEN_1 2'd1
`define MCIT_LEN_2 2'd2
`define MCIT_LEN_3 2'd3

// instruction cycle counts
`define MCIT_CYC_1 4'd1
`define MCIT_CYC_2 4'd2
`define MCIT_CYC_3 4'd3
`define MCIT_CYC_4 4'd4
`define MCIT_CYC_9 4'd9

// code_byte_move: cycle that sends the table address out, cycle that catches the byte
`define MCIT_TABLE_ADDR_CYC 4'd1
`define MCIT_TABLE_DATA_CYC 4'd2

// reset values
`define MCIT_RESET_PC 16'h0000
`define MCIT_PORT_RESET 8'hff

// internal extended RAM address width: 256 bytes, nothing beyond
`define MCIT_XRAM_AW 8

// port byte address is 10pp_0000, port bit address is 10pp_0bbb
`define MCIT_PORT_SPACE 2'b10
`define MCIT_PORT_LOW 4'h0
`define MCIT_PORT_IDX_HI 5
`define MCIT_PORT_IDX_LO 4
`define MCIT_BIT_BYTE_FLAG 3

// opcodes handled inside the block
`define MCIT_OP_JSET_CLR 8'h10
`define MCIT_OP_JB 8'h20
`define MCIT_OP_JNB 8'h30
`define MCIT_OP_JC 8'h40
`define MCIT_OP_JNC 8'h50
`define MCIT_OP_JZ 8'h60
`define MCIT_OP_JNZ 8'h70
`define MCIT_OP_LONG_JUMP 8'h02
`define MCIT_OP_LONG_CALL 8'h12
`define MCIT_OP_RET 8'h22
`define MCIT_OP_RETI 8'h32
`define MCIT_OP_JMP_IND 8'h73
`define MCIT_OP_TABLE_PC 8'h83
`define MCIT_OP_TABLE_DP 8'h93
`define MCIT_OP_ORL_DA 8'h42
`define MCIT_OP_ORL_DI 8'h43
`define MCIT_OP_ANL_DA 8'h52
`define MCIT_OP_ANL_DI 8'h53
`define MCIT_OP_XRL_DA 8'h62
`define MCIT_OP_XRL_DI 8'h63
`define MCIT_OP_INC_D 8'h05
`define MCIT_OP_DEC_D 8'h15
`define MCIT_OP_DEC_BNZ_D 8'hd5
`define MCIT_OP_CMP_BNE_AD 8'hb5
`define MCIT_OP_ORL_CB 8'h72
`define MCIT_OP_ANL_CB 8'h82
`define MCIT_OP_ORL_CNB 8'ha0
`define MCIT_OP_ANL_CNB 8'hb0
`define MCIT_OP_MOV_BC 8'h92
`define MCIT_OP_MOV_CB 8'ha2
`define MCIT_OP_CPL_B 8'hb2
`define MCIT_OP_CLR_B 8'hc2
`define MCIT_OP_SETB_B 8'hd2

`endif

// file: rtl/mcit_decode.v
// opcode decoder: length, cycle count and branch class of every opcode
`timescale 1ns/1ps
`include "mcit_regs.vh"

module mcit_decode (
  input wire [7:0] opcode,
  output reg [1:0] length,
  output reg [3:0] cycles,
  output reg is_branch,
  output reg always_taken
);

  always @* begin
    length = `MCIT_LEN_1;
    cycles = `MCIT_CYC_1;
    is_branch = 1'b0;
    always_taken = 1'b0;
    case (opcode[3:0])
      4'h0: begin
        case (opcode[7:4])
          4'h0: length = `MCIT_LEN_1;
          4'h1, 4'h2, 4'h3: begin
            length = `MCIT_LEN_3; cycles = `MCIT_CYC_4; is_branch = 1'b1;
          end
          4'h4, 4'h5, 4'h6, 4'h7: begin
            length = `MCIT_LEN_2; cycles = `MCIT_CYC_3; is_branch = 1'b1;
          end
          4'h8: begin
            length = `MCIT_LEN_2; cycles = `MCIT_CYC_3; is_branch = 1'b1; always_taken = 1'b1;
          end
          4'h9: begin
            length = `MCIT_LEN_3; cycles = `MCIT_CYC_3;
          end
          4'ha, 4'hb, 4'hc, 4'hd: begin
            length = `MCIT_LEN_2; cycles = `MCIT_CYC_2;
          end
          default: cycles = `MCIT_CYC_4;
        endcase
      end
      4'h1: begin
        length = `MCIT_LEN_2; cycles = `MCIT_CYC_3; is_branch = 1'b1; always_taken = 1'b1;
      end
      4'h2: begin
        case (opcode[7:4])
          4'h0, 4'h1: begin
            length = `MCIT_LEN_3; cycles = `MCIT_CYC_4; is_branch = 1'b1; always_taken = 1'b1;
          end
          4'h2, 4'h3: begin
            cycles = `MCIT_CYC_4; is_branch = 1'b1; always_taken = 1'b1;
          end
          4'he, 4'hf: cycles = `MCIT_CYC_4;
          default: begin
            length = `MCIT_LEN_2; cycles = `MCIT_CYC_2;
          end
        endcase
      end
      4'h3: begin
        case (opcode[7:4])
          4'h4, 4'h5, 4'h6: begin
            length = `MCIT_LEN_3; cycles = `MCIT_CYC_3;
          end
          4'h7: begin
            cycles = `MCIT_CYC_3; is_branch = 1'b1; always_taken = 1'b1;
          end
          4'h8, 4'h9, 4'he, 4'hf: cycles = `MCIT_CYC_4;
          4'ha: cycles = `MCIT_CYC_3;
          default: cycles = `MCIT_CYC_1;
        endcase
      end
      4'h4: begin
        case (opcode[7:4])
          4'h0, 4'h1, 4'hc, 4'he, 4'hf: cycles = `MCIT_CYC_1;
          4'h8, 4'ha: cycles = `MCIT_CYC_9;
          4'hb: begin
            length = `MCIT_LEN_3; cycles = `MCIT_CYC_4; is_branch = 1'b1;
          end
          4'hd: cycles = `MCIT_CYC_2;
          default: begin
            length = `MCIT_LEN_2; cycles = `MCIT_CYC_2;
          end
        endcase
      end
      4'h5: begin
        case (opcode[7:4])
          4'h7, 4'h8: begin
            length = `MCIT_LEN_3; cycles = `MCIT_CYC_3;
          end
          4'hb, 4'hd: begin
            length = `MCIT_LEN_3; cycles = `MCIT_CYC_4; is_branch = 1'b1;
          end
          4'ha: cycles = `MCIT_CYC_1;
          default: begin
            length = `MCIT_LEN_2; cycles = `MCIT_CYC_2;
          end
        endcase
      end
      4'h6, 4'h7: begin
        case (opcode[7:4])
          4'h7, 4'h8, 4'ha: begin
            length = `MCIT_LEN_2; cycles = `MCIT_CYC_2;
          end
          4'hb: begin
            length = `MCIT_LEN_3; cycles = `MCIT_CYC_4; is_branch = 1'b1;
          end
          default: cycles = `MCIT_CYC_2;
        endcase
      end
      default: begin
        case (opcode[7:4])
          4'h7, 4'h8, 4'ha: begin
            length = `MCIT_LEN_2; cycles = `MCIT_CYC_2;
          end
          4'hb: begin
            length = `MCIT_LEN_3; cycles = `MCIT_CYC_4; is_branch = 1'b1;
          end
          4'hd: begin
            length = `MCIT_LEN_2; cycles = `MCIT_CYC_3; is_branch = 1'b1;
          end
          default: cycles = `MCIT_CYC_1;
        endcase
      end
    endcase
  end

endmodule

// file: rtl/mcit_port.v
// one 8-bit port output latch with byte write and read-merge-write bit update
`timescale 1ns/1ps
`include "mcit_regs.vh"

module mcit_port (
  input wire clock,
  input wire arst_n,
  input wire byte_we,
  input wire [7:0] byte_data,
  input wire bit_we,
  input wire [2:0] bit_sel,
  input wire bit_value,
  output reg [7:0] latch
);

  reg [7:0] merged;

  // whole latch byte read, one bit altered, all eight written back
  always @* begin
    merged = latch;
    merged[bit_sel] = bit_value;
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      latch <= `MCIT_PORT_RESET;
    end else if (byte_we) begin
      latch <= byte_data;
    end else if (bit_we) begin
      latch <= merged;
    end
  end

endmodule

// file: verif/mcit_core_seq_props.sv
// port checker of the instruction sequencer
`timescale 1ns/1ps
module mcit_core_seq_props (
  input wire CLOCK,
  input wire ARST_N,
  input wire [7:0] CODE_DATA,
  input wire [7:0] ACC_IN,
  input wire [31:0] PORT_PIN_IN,
  input wire [31:0] PORT_LATCH_OUT,
  input wire INSTR_START,
  input wire EXEC_DONE,
  input wire [7:0] PORT_RDATA,
  input wire ACC_LOAD,
  input wire CARRY_LOAD,
  input wire CARRY_VALUE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  // ****************
  // properties
  // ****************
  chk_rot_single: assert property (INSTR_START && CODE_DATA inside {8'h03, 8'h13, 8'h33} |=> INSTR_START)
    else $error("rotate took more than one cycle");
  chk_three_move: assert property (INSTR_START && CODE_DATA inside {8'h85, 8'h75, 8'h90}
    |=> !INSTR_START [*2] ##1 INSTR_START)
    else $error("three byte move not three cycles");
  chk_code_read: assert property (INSTR_START && CODE_DATA inside {8'h83, 8'h93}
    |=> !INSTR_START [*3] ##1 (INSTR_START && ACC_LOAD))
    else $error("code byte read not four cycles");
  chk_xram_four: assert property (INSTR_START && CODE_DATA inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3}
    |=> !INSTR_START [*3] ##1 INSTR_START)
    else $error("ext ram move not four cycles");
  chk_short_branch: assert property (INSTR_START && CODE_DATA inside {8'h01, 8'h11, 8'h80, 8'h40, 8'h50, 8'h60,
    8'h70, 8'hd8} |=> !INSTR_START [*2] ##1 INSTR_START)
    else $error("two byte branch not three cycles");
  chk_long_branch: assert property (INSTR_START && CODE_DATA inside {8'h02, 8'h12, 8'h20, 8'h30, 8'h10, 8'hb4,
    8'hb5, 8'hb6, 8'hb8, 8'hd5} |=> !INSTR_START [*3] ##1 INSTR_START)
    else $error("three byte branch not four cycles");
  chk_done_start: assert property (INSTR_START && CODE_DATA inside {8'h84, 8'ha4}
    |=> !INSTR_START [*8] ##1 (INSTR_START && EXEC_DONE))
    else $error("next fetch not held for nine cycles");
  chk_or_latch: assert property (INSTR_START && CODE_DATA == 8'h42 ##1 CODE_DATA == 8'h90
    |=> PORT_LATCH_OUT[15:8] == ($past(PORT_LATCH_OUT[15:8]) | $past(ACC_IN))
    && PORT_RDATA == $past(PORT_LATCH_OUT[15:8]))
    else $error("port or did not use the latch");
  chk_bit_merge: assert property (INSTR_START && CODE_DATA == 8'hc2 ##1 CODE_DATA == 8'h93
    |=> PORT_LATCH_OUT[15:8] == ($past(PORT_LATCH_OUT[15:8]) & 8'hf7))
    else $error("bit clear disturbed other latch bits");
  chk_pin_carry: assert property (INSTR_START && CODE_DATA == 8'ha2 ##1 CODE_DATA == 8'h90
    |=> CARRY_LOAD && CARRY_VALUE == $past(PORT_PIN_IN[8]))
    else $error("bit input did not read the pin");

  cov_jump_clear_port: cover property (INSTR_START && CODE_DATA == 8'h10 ##1 CODE_DATA[7:3] == 5'b10010);
  cov_acc_load: cover property (ACC_LOAD);
  cov_carry_load: cover property (CARRY_LOAD);
endmodule

// file: verif/mcit_prog_mem.sv
// program memory and port pin model at the far side of the sequencer
`timescale 1ns/1ps
module mcit_prog_mem (
  input wire [15:0] code_addr,
  output wire [7:0] code_data,
  input wire [31:0] latch,
  input wire [31:0] ext_low,
  output wire [31:0] pins
);
  logic [7:0] mem [0:4095];
  // asynchronous read: the byte is valid in the cycle that addresses it
  assign code_data = mem[code_addr[11:0]];
  // pull-up pins; an outside load may hold a pin low while its latch bit is 1
  assign pins = latch & ~ext_low;
endmodule

// file: verif/tb_top.sv
// self-checking bench of the instruction sequencer
`timescale 1ns/1ps
module tb_top;
  logic clock, arst_n, carry_in, cond_in, port_wr_en;
  logic [7:0] acc_in, reg_ind_in, port_wr_data;
  logic [15:0] data_pointer, ret_addr_in, max_addr;
  logic [1:0] port_wr_sel;
  logic [31:0] ext_low;
  wire [15:0] code_addr;
  wire [7:0] code_data, exec_opcode, exec_operand1, exec_operand2, port_rdata, acc_value;
  wire [31:0] pins, latch;
  wire instr_start, exec_done, branch_taken, acc_load, carry_load, carry_value;
  int n_mismatch = 0;
  int checks = 0;
  // opcode, length (0 for branches), cycles
  logic [15:0] tab [66] = '{
    16'h3311, 16'h0311, 16'h1311, 16'he811, 16'he612, 16'hf811, 16'hf612, 16'he522, 16'h7422, 16'h7822,
    16'hf522, 16'ha822, 16'h8822, 16'h7622, 16'h8622, 16'ha622, 16'h8533, 16'h7533, 16'h9033, 16'h9314,
    16'h8314, 16'he214, 16'he014, 16'hf214, 16'hf014, 16'hc022, 16'hd022, 16'hc811, 16'hc612, 16'hd612,
    16'hc522, 16'hc311, 16'hc222, 16'hd311, 16'hd222, 16'hb311, 16'hb222, 16'h8222, 16'hb022, 16'h7222,
    16'ha022, 16'ha222, 16'h9222, 16'h7303, 16'h2204, 16'h3204, 16'h1103, 16'h0103, 16'h8003, 16'h4003,
    16'h5003, 16'h6003, 16'h7003, 16'hd803, 16'h0204, 16'h1204, 16'h2004, 16'h3004, 16'h1004, 16'hb504,
    16'hb404, 16'hb804, 16'hb604, 16'hd504, 16'ha419, 16'h8419};

  mcit_core_seq dut (
    .CLOCK(clock), .ARST_N(arst_n), .CODE_ADDR(code_addr), .CODE_DATA(code_data), .ACC_IN(acc_in),
    .CARRY_IN(carry_in), .DATA_POINTER_IN(data_pointer), .REG_IND_IN(reg_ind_in), .COND_IN(cond_in),
    .RET_ADDR_IN(ret_addr_in), .PORT_PIN_IN(pins), .PORT_WR_EN(port_wr_en), .PORT_WR_SEL(port_wr_sel),
    .PORT_WR_DATA(port_wr_data), .PORT_LATCH_OUT(latch), .INSTR_START(instr_start), .EXEC_DONE(exec_done),
    .EXEC_OPCODE(exec_opcode), .EXEC_OPERAND1(exec_operand1), .EXEC_OPERAND2(exec_operand2),
    .BRANCH_TAKEN(branch_taken),
    .PORT_RDATA(port_rdata), .ACC_LOAD(acc_load), .ACC_VALUE(acc_value), .CARRY_LOAD(carry_load),
    .CARRY_VALUE(carry_value));

  mcit_prog_mem u_mem (
    .code_addr(code_addr), .code_data(code_data), .latch(latch), .ext_low(ext_low), .pins(pins));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************
  // helpers
  // ****************
  task automatic hold_reset;
    @(posedge clock);
    arst_n <= 1'b0;
    for (int i = 0; i < 4096; i++)
      u_mem.mem[i] = 8'h30;
    repeat (2) @(posedge clock);
  endtask

  task automatic release_reset;
    arst_n <= 1'b1;
    @(negedge clock);
  endtask

  // bounded wait for the next fetch, done or accumulator load
  task automatic wait_for(input int which, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < 40) begin
      @(negedge clock);
      n++;
      if (code_addr > max_addr)
        max_addr = code_addr;
      hit = (which == 0) ? (instr_start === 1'b1) : (which == 1) ? (exec_done === 1'b1) : (acc_load === 1'b1);
    end
    if (!hit) begin
      n_mismatch++;
      $display("wrong value at %0t: wait ran out, got %0h expected %0h", $time, 0, 1);
      wrap_up();
    end
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic test_cycles;
    int gap;
    foreach (tab[i]) begin
      hold_reset();
      u_mem.mem[0] = tab[i][15:8];
      release_reset();
      wait_for(0, gap);
      check(gap, tab[i][3:0]);
      if (tab[i][7:4] != 4'h0)
        check(code_addr, tab[i][7:4]);
    end
    $display("test cycle counts finished");
  endtask

  task automatic test_xram;
    int n;
    hold_reset();
    u_mem.mem[0] = 8'hf0;
    u_mem.mem[1] = 8'he2;
    acc_in <= 8'h5a;
    data_pointer <= 16'h0155;
    reg_ind_in <= 8'h55;
    release_reset();
    max_addr = 16'h0000;
    wait_for(2, n);
    check(acc_value, 8'h5a);
    check(max_addr, 16'h0002);
    $display("test ext ram finished");
  endtask

  task automatic test_code_read;
    int n;
    hold_reset();
    u_mem.mem[0] = 8'h93;
    u_mem.mem[1] = 8'h83;
    u_mem.mem[12'h102] = 8'hc4;
    u_mem.mem[4] = 8'h7e;
    acc_in <= 8'h02;
    data_pointer <= 16'h0100;
    release_reset();
    wait_for(2, n);
    check(acc_value, 8'hc4);
    wait_for(2, n);
    check(acc_value, 8'h7e);
    $display("test code read finished");
  endtask

  // pins 0..3 of port 1 held low outside, so pin and latch reads differ
  task automatic test_ports;
    logic [7:0] prog [26] = '{8'ha2, 8'h90, 8'h42, 8'h90, 8'hc2, 8'h93, 8'hd2, 8'h93, 8'hb2, 8'h91, 8'h92, 8'h92,
      8'h10, 8'h90, 8'h00, 8'h05, 8'h90, 8'h15, 8'h90, 8'h62, 8'h90, 8'h52, 8'h90, 8'hd5, 8'h90, 8'h00};
    logic [15:0] exp [12] = '{16'ha2ff, 16'h42ff, 16'hc2f7, 16'hd2ff, 16'hb2fd, 16'h92f9, 16'h10f8, 16'h05f9,
      16'h15f8, 16'h62f8, 16'h5200, 16'hd5ff};
    logic [7:0] prev;
    int n, pos;
    hold_reset();
    foreach (prog[i])
      u_mem.mem[i] = prog[i];
    acc_in <= 8'h00;
    carry_in <= 1'b0;
    ext_low <= 32'h0000_0f00;
    release_reset();
    prev = 8'hff;
    pos = 0;
    foreach (exp[i]) begin
      wait_for(1, n);
      check(exec_opcode, exp[i][15:8]);
      check(exec_operand1, prog[pos + 1]);
      if (exp[i][15:8] inside {8'h10, 8'hd5})
        check(exec_operand2, prog[pos + 2]);
      check(latch[15:8], exp[i][7:0]);
      if (exp[i][15:8] inside {8'h42, 8'h05, 8'h15, 8'h62, 8'h52, 8'hd5})
        check(port_rdata, prev);
      if (exp[i][15:8] inside {8'h10, 8'hd5})
        check(branch_taken, 1'b1);
      if (exp[i][15:8] == 8'ha2)
        check(carry_value, 1'b0);
      prev = exp[i][7:0];
      pos = pos + ((exp[i][15:8] inside {8'h10, 8'hd5}) ? 3 : 2);
    end
    $display("test port access finished");
  endtask

  initial begin
    arst_n = 1'b0;
    carry_in = 1'b0;
    cond_in = 1'b0;
    port_wr_en = 1'b0;
    acc_in = 8'h00;
    reg_ind_in = 8'h00;
    port_wr_data = 8'h00;
    data_pointer = 16'h0000;
    ret_addr_in = 16'h0000;
    port_wr_sel = 2'h0;
    ext_low = 32'h0000_0000;
    max_addr = 16'h0000;
    repeat (20) @(posedge clock);
    test_cycles();
    test_xram();
    test_code_read();
    test_ports();
    wrap_up();
  end
endmodule

bind mcit_core_seq mcit_core_seq_props u_props (
  .CLOCK(CLOCK), .ARST_N(ARST_N), .CODE_DATA(CODE_DATA), .ACC_IN(ACC_IN), .PORT_PIN_IN(PORT_PIN_IN),
  .PORT_LATCH_OUT(PORT_LATCH_OUT), .INSTR_START(INSTR_START), .EXEC_DONE(EXEC_DONE), .PORT_RDATA(PORT_RDATA),
  .ACC_LOAD(ACC_LOAD), .CARRY_LOAD(CARRY_LOAD), .CARRY_VALUE(CARRY_VALUE));
